/* src/pcra_bus_if.sv */
// Purpose: Multiplexed memory bus between controller and memory end
// Assumes: Both ends clocked by the same pclk
// Notes: Shared data lines resolved from the two enables
`timescale 1ns/1ps
interface pcra_bus_if;
  logic ce_n;
  logic we_n;
  logic oe_n;
  logic adv_n;
  logic config_select_pin;
  logic [4:0] a_hi;
  logic [15:0] host_dq;
  logic host_dq_oe_n;
  logic [15:0] dev_dq;
  logic dev_dq_oe_n;
  logic wait_pin;
  logic [15:0] dq;
  // Undriven lines read as zero
  assign dq = !dev_dq_oe_n ? dev_dq : (!host_dq_oe_n ? host_dq : 16'h0000);
  modport host (output ce_n, we_n, oe_n, adv_n, config_select_pin, a_hi, host_dq, host_dq_oe_n,
                input dq, wait_pin);
  modport dev (input ce_n, we_n, oe_n, adv_n, config_select_pin, a_hi, dq,
               output dev_dq, dev_dq_oe_n, wait_pin);
endinterface : pcra_bus_if

/* src/pcra_ctrl_end.sv */
// Purpose: Controller end: runs register and array accesses ordered over APB
// Assumes: Memory end shares pclk
// Notes: One command at a time; commands while busy are dropped
`timescale 1ns/1ps
module pcra_ctrl_end (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic op_busy,
  pcra_bus_if.host b
);
  typedef enum logic [1:0] {HS_IDLE, HS_ADDR, HS_ACT, HS_GAP} pcra_hstate_t;
  pcra_hstate_t state_ff, nxt_state;
  logic [1:0] step_ff, nxt_step;
  logic [2:0] cnt_ff, nxt_cnt;
  logic [2:0] cmd_ff, nxt_cmd;
  logic [20:0] addr_ff, nxt_addr;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] rdata_ff, nxt_rdata;
  logic [31:0] prdata_ff, nxt_prdata;
  logic ce_n_ff, nxt_ce_n, we_n_ff, nxt_we_n, oe_n_ff, nxt_oe_n;
  logic adv_n_ff, nxt_adv_n, cre_ff, nxt_cre;
  logic [4:0] a_hi_ff, nxt_a_hi;
  logic [15:0] dq_ff, nxt_dq;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic is_sw, is_pin, op_rd, wr, mapped, cmd_ok;
  logic [1:0] last_step;
  logic [20:0] op_addr;
  logic [15:0] op_data;

  // ==========================================================
  // Next state
  always_comb begin
    is_sw = cmd_ff == pcra_pkg::CMD_SW_RD || cmd_ff == pcra_pkg::CMD_SW_WR;
    is_pin = cmd_ff == pcra_pkg::CMD_PIN_RD || cmd_ff == pcra_pkg::CMD_PIN_WR;
    last_step = is_sw ? pcra_pkg::SW_LAST_STEP : 2'h0;
    // Two reads, selector write, then read or write
    op_rd = is_sw ? (step_ff < pcra_pkg::SW_SEL_STEP ||
                     (step_ff == pcra_pkg::SW_LAST_STEP && cmd_ff == pcra_pkg::CMD_SW_RD))
                  : (cmd_ff == pcra_pkg::CMD_ARR_RD || cmd_ff == pcra_pkg::CMD_PIN_RD);
    op_addr = is_sw ? pcra_pkg::TOP_ADDR : addr_ff;
    op_data = (is_sw && step_ff == pcra_pkg::SW_SEL_STEP) ? addr_ff[15:0] : wdata_ff;
    mapped = paddr == pcra_pkg::REG_CMD || paddr == pcra_pkg::REG_ADDR ||
             paddr == pcra_pkg::REG_WDATA || paddr == pcra_pkg::REG_RDATA ||
             paddr == pcra_pkg::REG_STATUS;
    wr = psel && penable && pwrite;
    cmd_ok = pwdata[2:0] <= pcra_pkg::CMD_SW_WR;
    nxt_state = state_ff;
    nxt_step = step_ff;
    nxt_cnt = cnt_ff;
    nxt_cmd = cmd_ff;
    nxt_addr = addr_ff;
    nxt_wdata = wdata_ff;
    nxt_rdata = rdata_ff;
    nxt_prdata = prdata_ff;
    nxt_ce_n = ce_n_ff;
    nxt_we_n = we_n_ff;
    nxt_oe_n = oe_n_ff;
    nxt_adv_n = adv_n_ff;
    nxt_cre = cre_ff;
    nxt_a_hi = a_hi_ff;
    nxt_dq = dq_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    if (wr && paddr == pcra_pkg::REG_ADDR) begin
      nxt_addr = pwdata[20:0];
    end
    if (wr && paddr == pcra_pkg::REG_WDATA) begin
      nxt_wdata = pwdata[15:0];
    end
    if (psel && !penable && !pwrite) begin
      nxt_prdata = 32'h00000000;
      if (paddr == pcra_pkg::REG_CMD) nxt_prdata = {29'h0, cmd_ff};
      if (paddr == pcra_pkg::REG_ADDR) nxt_prdata = {11'h0, addr_ff};
      if (paddr == pcra_pkg::REG_WDATA) nxt_prdata = {16'h0, wdata_ff};
      if (paddr == pcra_pkg::REG_RDATA) nxt_prdata = {16'h0, rdata_ff};
      if (paddr == pcra_pkg::REG_STATUS) nxt_prdata = {31'h0, state_ff != HS_IDLE};
    end
    unique case (state_ff)
      HS_IDLE: begin
        // Orders start only from standby
        if (wr && paddr == pcra_pkg::REG_CMD && cmd_ok) begin
          nxt_cmd = pwdata[2:0];
          nxt_step = 2'h0;
          nxt_state = HS_ADDR;
        end
      end
      HS_ADDR: begin
        nxt_ce_n = 1'b0;
        nxt_adv_n = 1'b0;
        nxt_cre = is_pin;
        nxt_a_hi = op_addr[20:16];
        nxt_dq = op_addr[15:0];
        nxt_dq_oe_n = 1'b0;
        nxt_cnt = 3'h0;
        nxt_state = HS_ACT;
      end
      HS_ACT: begin
        nxt_cnt = cnt_ff + 3'h1;
        if (cnt_ff == 3'h0) begin
          nxt_adv_n = 1'b1;
          nxt_oe_n = !op_rd;
          nxt_we_n = op_rd;
          nxt_dq = op_data;
          nxt_dq_oe_n = op_rd;
        end else if (op_rd ? cnt_ff == pcra_pkg::HOST_RD_CYC : cnt_ff == pcra_pkg::HOST_WR_CYC) begin
          // Chip select held low until the word is taken
          if (op_rd) nxt_rdata = b.dq;
          nxt_ce_n = 1'b1;
          nxt_we_n = 1'b1;
          nxt_oe_n = 1'b1;
          nxt_cre = 1'b0;
          nxt_dq_oe_n = 1'b1;
          nxt_state = HS_GAP;
        end
      end
      HS_GAP: begin
        nxt_step = step_ff + 2'h1;
        nxt_state = (step_ff == last_step) ? HS_IDLE : HS_ADDR;
      end
    endcase
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= HS_IDLE;
      step_ff <= 2'h0;
      cnt_ff <= 3'h0;
      cmd_ff <= 3'h0;
      addr_ff <= 21'h000000;
      wdata_ff <= 16'h0000;
      rdata_ff <= 16'h0000;
      prdata_ff <= 32'h00000000;
      ce_n_ff <= 1'b1;
      we_n_ff <= 1'b1;
      oe_n_ff <= 1'b1;
      adv_n_ff <= 1'b1;
      cre_ff <= 1'b0;
      a_hi_ff <= 5'h00;
      dq_ff <= 16'h0000;
      dq_oe_n_ff <= 1'b1;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      step_ff <= nxt_step;
      cnt_ff <= nxt_cnt;
      cmd_ff <= nxt_cmd;
      addr_ff <= nxt_addr;
      wdata_ff <= nxt_wdata;
      rdata_ff <= nxt_rdata;
      prdata_ff <= nxt_prdata;
      ce_n_ff <= nxt_ce_n;
      we_n_ff <= nxt_we_n;
      oe_n_ff <= nxt_oe_n;
      adv_n_ff <= nxt_adv_n;
      cre_ff <= nxt_cre;
      a_hi_ff <= nxt_a_hi;
      dq_ff <= nxt_dq;
      dq_oe_n_ff <= nxt_dq_oe_n;
    end
  end

  assign prdata = prdata_ff;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign op_busy = state_ff != HS_IDLE;
  assign b.ce_n = ce_n_ff;
  assign b.we_n = we_n_ff;
  assign b.oe_n = oe_n_ff;
  assign b.adv_n = adv_n_ff;
  assign b.config_select_pin = cre_ff;
  assign b.a_hi = a_hi_ff;
  assign b.host_dq = dq_ff;
  assign b.host_dq_oe_n = dq_oe_n_ff;
endmodule : pcra_ctrl_end

/* src/pcra_mem_end.sv */
// Purpose: Memory end: configuration registers behind the multiplexed bus
// Assumes: Bus pins change on pclk edges; array storage on the user side
// Notes: Array reads return arr_rdata for the latched address
//
// The APB register port and the address map are this design's own decisions.
`timescale 1ns/1ps
// Notes on behaviour
// - Select field 00 refresh, 10 bus, 01 identity
// - Controller raises select pin for pin access
// - Controller holds chip select through wait cycles
// - Two reads, two writes load a register
// - Fourth step read returns selected register
// - Sequence uses top address, array untouched
// - Third write word picks the register
// - Fourth step moves all sixteen bits
// - Both access methods always available
// - Bus setup resets to 1d1f
// - Bit 15 picks synchronous or asynchronous mode
// - Bit 14 picks variable or fixed latency
// - Bits 13..11 give latency count
// - Bit 10 sets wait polarity
// - Bit 8 sets wait one cycle early
// - Bit 3 picks wrap or no wrap
// - Bits 2..0 give burst length
// - Burst settings govern reads and writes
// - Identity register ignores writes
// - Controller changes registers only in standby
// - Pin write value travels as address
module pcra_mem_end #(
  parameter logic [15:0] REFRESH_RST = pcra_pkg::REFRESH_SETUP_RST,
  parameter logic [15:0] IDENTITY = pcra_pkg::IDENTITY_VAL
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  pcra_bus_if.dev b,
  output logic arr_wr,
  output logic [20:0] arr_addr,
  output logic [15:0] arr_wdata,
  input wire logic [15:0] arr_rdata,
  output logic sync_mode,
  output logic fixed_latency,
  output logic [3:0] latency_cycles,
  output logic wait_active_high,
  output logic wait_early,
  output logic burst_wrap,
  output logic [4:0] burst_words,
  output logic burst_continuous,
  output logic setup_unsupported,
  output logic [15:0] refresh_setup
);
  typedef enum logic [1:0] {DS_IDLE, DS_RD, DS_WR} pcra_dstate_t;
  typedef enum logic [1:0] {SQ_NONE, SQ_R1, SQ_R2, SQ_SEL} pcra_seq_t;
  pcra_dstate_t state_ff, nxt_state;
  pcra_seq_t seq_ff, nxt_seq;
  logic [20:0] addr_ff, nxt_addr;
  logic cre_ff, nxt_cre;
  logic [15:0] wdata_ff, nxt_wdata;
  logic [15:0] dq_out_ff, nxt_dq_out;
  logic dq_oe_n_ff, nxt_dq_oe_n;
  logic [1:0] cnt_ff, nxt_cnt;
  logic [1:0] sel_ff, nxt_sel;
  logic [15:0] bus_setup_ff, nxt_bus_setup;
  logic [15:0] refresh_ff, nxt_refresh;
  logic arr_wr_ff, nxt_arr_wr;
  logic is_top, wr_en, wait_act;
  logic [1:0] rsel, wr_sel;
  logic [15:0] reg_rd, rd_val, wr_val;
  logic [2:0] lat_code, bl_code;

  // ==========================================================
  // Bus decode and register access
  always_comb begin
    nxt_state = state_ff;
    nxt_seq = seq_ff;
    nxt_addr = addr_ff;
    nxt_cre = cre_ff;
    nxt_wdata = wdata_ff;
    nxt_dq_out = dq_out_ff;
    nxt_dq_oe_n = dq_oe_n_ff;
    nxt_cnt = cnt_ff;
    nxt_sel = sel_ff;
    nxt_bus_setup = bus_setup_ff;
    nxt_refresh = refresh_ff;
    nxt_arr_wr = 1'b0;
    wr_en = 1'b0;
    wr_sel = sel_ff;
    wr_val = wdata_ff;
    is_top = addr_ff == pcra_pkg::TOP_ADDR;
    rsel = cre_ff ? addr_ff[pcra_pkg::PIN_SEL_LSB +: 2] : sel_ff;
    reg_rd = IDENTITY;
    unique case (rsel)
      pcra_pkg::PIN_SEL_REFRESH: reg_rd = refresh_ff;
      pcra_pkg::PIN_SEL_BUS: reg_rd = bus_setup_ff;
      default: reg_rd = IDENTITY;
    endcase
    rd_val = (cre_ff || (is_top && seq_ff == SQ_SEL)) ? reg_rd : arr_rdata;
    if (!b.ce_n && !b.adv_n) begin
      // Either access method may open any cycle
      nxt_addr = {b.a_hi, b.dq};
      nxt_cre = b.config_select_pin;
      nxt_state = DS_IDLE;
      nxt_dq_oe_n = 1'b1;
    end else begin
      unique case (state_ff)
        DS_IDLE: begin
          nxt_cnt = 2'h0;
          if (!b.ce_n && !b.oe_n) begin
            nxt_state = DS_RD;
          end else if (!b.ce_n && !b.we_n) begin
            nxt_state = DS_WR;
            nxt_wdata = b.dq;
          end
        end
        DS_RD: begin
          if (b.ce_n || b.oe_n) begin
            nxt_state = DS_IDLE;
            nxt_dq_oe_n = 1'b1;
            nxt_seq = SQ_NONE;
            if (!cre_ff && is_top && seq_ff != SQ_SEL) begin
              nxt_seq = (seq_ff == SQ_NONE) ? SQ_R1 : SQ_R2;
            end
          end else if (cnt_ff != pcra_pkg::RD_LAT) begin
            nxt_cnt = cnt_ff + 2'h1;
            if (cnt_ff == pcra_pkg::RD_LAT - 2'h1) begin
              nxt_dq_out = rd_val;
              nxt_dq_oe_n = 1'b0;
            end
          end
        end
        DS_WR: begin
          if (b.ce_n || b.we_n) begin
            // First rising edge of chip select or write strobe commits
            nxt_state = DS_IDLE;
            nxt_seq = SQ_NONE;
            if (cre_ff) begin
              wr_en = 1'b1;
              wr_sel = addr_ff[pcra_pkg::PIN_SEL_LSB +: 2];
              wr_val = addr_ff[15:0];
            end else if (is_top && seq_ff == SQ_R2) begin
              nxt_seq = SQ_SEL;
              if (wdata_ff == pcra_pkg::SW_SEL_REFRESH) begin
                nxt_sel = pcra_pkg::PIN_SEL_REFRESH;
              end else if (wdata_ff == pcra_pkg::SW_SEL_BUS) begin
                nxt_sel = pcra_pkg::PIN_SEL_BUS;
              end else if (wdata_ff == pcra_pkg::SW_SEL_ID) begin
                nxt_sel = pcra_pkg::PIN_SEL_ID;
              end else begin
                nxt_seq = SQ_NONE;
              end
            end else if (is_top && seq_ff == SQ_SEL) begin
              wr_en = 1'b1;
            end else begin
              nxt_arr_wr = 1'b1;
            end
          end else begin
            nxt_wdata = b.dq;
          end
        end
        default: nxt_state = DS_IDLE;
      endcase
    end
    // Identity stays fixed
    if (wr_en && wr_sel == pcra_pkg::PIN_SEL_BUS) begin
      nxt_bus_setup = wr_val;
    end else if (wr_en && wr_sel == pcra_pkg::PIN_SEL_REFRESH) begin
      nxt_refresh = wr_val;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= DS_IDLE;
      seq_ff <= SQ_NONE;
      addr_ff <= 21'h000000;
      cre_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      dq_out_ff <= 16'h0000;
      dq_oe_n_ff <= 1'b1;
      cnt_ff <= 2'h0;
      sel_ff <= pcra_pkg::PIN_SEL_REFRESH;
      bus_setup_ff <= pcra_pkg::BUS_SETUP_RST;
      refresh_ff <= REFRESH_RST;
      arr_wr_ff <= 1'b0;
    end else if (clk_en) begin
      state_ff <= nxt_state;
      seq_ff <= nxt_seq;
      addr_ff <= nxt_addr;
      cre_ff <= nxt_cre;
      wdata_ff <= nxt_wdata;
      dq_out_ff <= nxt_dq_out;
      dq_oe_n_ff <= nxt_dq_oe_n;
      cnt_ff <= nxt_cnt;
      sel_ff <= nxt_sel;
      bus_setup_ff <= nxt_bus_setup;
      refresh_ff <= nxt_refresh;
      arr_wr_ff <= nxt_arr_wr;
    end
  end

  // ==========================================================
  // Wait pin and field decode
  always_comb begin
    wait_act = 1'b0;
    if (state_ff == DS_RD) begin
      wait_act = bus_setup_ff[pcra_pkg::BS_WAIT_EARLY] ?
                 cnt_ff < pcra_pkg::RD_LAT - 2'h1 : cnt_ff < pcra_pkg::RD_LAT;
    end
    lat_code = bus_setup_ff[pcra_pkg::BS_LAT_LSB +: 3];
    bl_code = bus_setup_ff[pcra_pkg::BS_BL_LSB +: 3];
    latency_cycles = (lat_code == pcra_pkg::LAT_CODE_9) ?
                     pcra_pkg::LAT_CYC_9 : {1'b0, lat_code} + pcra_pkg::LAT_OFFSET;
    unique case (bl_code)
      pcra_pkg::BL_4: burst_words = pcra_pkg::WORDS_4;
      pcra_pkg::BL_8: burst_words = pcra_pkg::WORDS_8;
      pcra_pkg::BL_16: burst_words = pcra_pkg::WORDS_16;
      default: burst_words = 5'h00;
    endcase
    setup_unsupported = lat_code == pcra_pkg::LAT_RSV_A || lat_code == pcra_pkg::LAT_RSV_B ||
                        (burst_words == 5'h00 && bl_code != pcra_pkg::BL_CONT) ||
                        bus_setup_ff[pcra_pkg::BS_DRV_LSB +: 2] == pcra_pkg::DRV_RSV ||
                        (bus_setup_ff & pcra_pkg::BS_RSV_MASK) != 16'h0000;
  end

  assign b.wait_pin = bus_setup_ff[pcra_pkg::BS_WAIT_POL] ? wait_act : !wait_act;
  assign b.dev_dq = dq_out_ff;
  assign b.dev_dq_oe_n = dq_oe_n_ff;
  assign arr_wr = arr_wr_ff;
  assign arr_addr = addr_ff;
  assign arr_wdata = wdata_ff;
  assign sync_mode = !bus_setup_ff[pcra_pkg::BS_MODE];
  assign fixed_latency = bus_setup_ff[pcra_pkg::BS_FIXED];
  assign wait_active_high = bus_setup_ff[pcra_pkg::BS_WAIT_POL];
  assign wait_early = bus_setup_ff[pcra_pkg::BS_WAIT_EARLY];
  // One wrap and length pair serves both directions
  assign burst_wrap = !bus_setup_ff[pcra_pkg::BS_WRAP];
  assign burst_continuous = bl_code == pcra_pkg::BL_CONT;
  assign refresh_setup = refresh_ff;
endmodule : pcra_mem_end

/* src/pcra_pkg.sv */
// Purpose: Shared constants for the configuration register access block
// Assumes: One pclk domain for both ends
// Notes: Field positions refer to the bus setup register
package pcra_pkg;
  // ==========================================================
  // Bus shape
  localparam int ADDR_W = 21;
  localparam int DATA_W = 16;
  localparam int AHI_W = 5;
  localparam logic [20:0] TOP_ADDR = 21'h1fffff;
  // ==========================================================
  // Register selection
  localparam int PIN_SEL_LSB = 18;
  localparam logic [1:0] PIN_SEL_REFRESH = 2'h0;
  localparam logic [1:0] PIN_SEL_BUS = 2'h2;
  localparam logic [1:0] PIN_SEL_ID = 2'h1;
  localparam logic [15:0] SW_SEL_REFRESH = 16'h0000;
  localparam logic [15:0] SW_SEL_BUS = 16'h0001;
  localparam logic [15:0] SW_SEL_ID = 16'h0002;
  // ==========================================================
  // Reset values
  localparam logic [15:0] BUS_SETUP_RST = 16'h1d1f;
  localparam logic [15:0] REFRESH_SETUP_RST = 16'h0010;
  // Arbitrary identity value
  localparam logic [15:0] IDENTITY_VAL = 16'h5a3c;
  // ==========================================================
  // Bus setup fields
  localparam int BS_MODE = 15;
  localparam int BS_FIXED = 14;
  localparam int BS_LAT_LSB = 11;
  localparam int BS_WAIT_POL = 10;
  localparam int BS_WAIT_EARLY = 8;
  localparam int BS_DRV_LSB = 4;
  localparam int BS_WRAP = 3;
  localparam int BS_BL_LSB = 0;
  localparam logic [15:0] BS_RSV_MASK = 16'h02c0;
  localparam logic [1:0] DRV_RSV = 2'h3;
  localparam logic [2:0] LAT_CODE_9 = 3'h0;
  localparam logic [2:0] LAT_RSV_A = 3'h1;
  localparam logic [2:0] LAT_RSV_B = 3'h7;
  localparam logic [3:0] LAT_CYC_9 = 4'h9;
  localparam logic [3:0] LAT_OFFSET = 4'h1;
  localparam logic [2:0] BL_4 = 3'h1;
  localparam logic [2:0] BL_8 = 3'h2;
  localparam logic [2:0] BL_16 = 3'h3;
  localparam logic [2:0] BL_CONT = 3'h7;
  localparam logic [4:0] WORDS_4 = 5'h04;
  localparam logic [4:0] WORDS_8 = 5'h08;
  localparam logic [4:0] WORDS_16 = 5'h10;
  // ==========================================================
  // Timing in pclk cycles and software sequence steps
  localparam logic [1:0] RD_LAT = 2'h2;
  localparam logic [2:0] HOST_RD_CYC = 3'(RD_LAT) + 3'h2;
  localparam logic [2:0] HOST_WR_CYC = 3'h2;
  localparam logic [1:0] SW_SEL_STEP = 2'h2;
  localparam logic [1:0] SW_LAST_STEP = 2'h3;
  // ==========================================================
  // Controller registers and commands
  localparam logic [11:0] REG_CMD = 12'h000;
  localparam logic [11:0] REG_ADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_RDATA = 12'h00c;
  localparam logic [11:0] REG_STATUS = 12'h010;
  localparam logic [2:0] CMD_ARR_RD = 3'h0;
  localparam logic [2:0] CMD_ARR_WR = 3'h1;
  localparam logic [2:0] CMD_PIN_RD = 3'h2;
  localparam logic [2:0] CMD_PIN_WR = 3'h3;
  localparam logic [2:0] CMD_SW_RD = 3'h4;
  localparam logic [2:0] CMD_SW_WR = 3'h5;
endpackage : pcra_pkg

/* test/pcra_bus_checker.sv */
// Purpose: Wire checks on the multiplexed bus between the two ends
// Assumes: One pclk domain, presetn low resets both ends
// Notes: Instantiated beside the interface, no bind
`timescale 1ns/1ps
module pcra_bus_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce_n,
  input wire logic we_n,
  input wire logic oe_n,
  input wire logic adv_n,
  input wire logic host_dq_oe_n,
  input wire logic dev_dq_oe_n
);
  // ==========================================================
  // Bus protocol properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_ADV_IN_CE: assert property (!adv_n |-> !ce_n)
    else $error("address latch outside chip select");
  AST_ADDR_DRIVEN: assert property ($fell(adv_n) |-> !host_dq_oe_n ##1 adv_n)
    else $error("address phase not driven for one cycle");
  AST_STROBE_IN_CE: assert property ((!we_n || !oe_n) |-> !ce_n)
    else $error("strobe active without chip select");
  AST_RW_EXCL: assert property (!oe_n |-> we_n)
    else $error("read and write strobes together");
  AST_RD_LATENCY: assert property ($fell(oe_n) |-> dev_dq_oe_n [*3] ##1 !dev_dq_oe_n)
    else $error("read data not driven at the fixed latency");
  AST_DEV_IN_READ: assert property (!dev_dq_oe_n |-> !$past(ce_n) && !$past(oe_n))
    else $error("memory drives outside a read");
  AST_RD_RELEASE: assert property ($rose(oe_n) |=> dev_dq_oe_n)
    else $error("memory keeps driving after read ends");
  AST_CE_GAP: assert property ($rose(ce_n) |=> ce_n)
    else $error("operations closer than two idle cycles");
endmodule : pcra_bus_checker

/* test/psram_config_register_access_tb.sv */
// Purpose: Self-checking bench for both ends joined by the bus
// Assumes: Bench is the APB master and holds the array storage
// Notes: Results compared with an integer model
`timescale 1ns/1ps
module psram_config_register_access_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic clk_en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, q;
  logic pready, pslverr, op_busy, arr_wr, err;
  logic [20:0] arr_addr;
  logic [15:0] arr_wdata, arr_rdata, refresh_setup, dec;
  logic sync_mode, fixed_latency, wait_active_high, wait_early, burst_wrap, burst_continuous, setup_unsupported;
  logic [3:0] latency_cycles;
  logic [4:0] burst_words;
  logic [15:0] mem [0:15];
  int n_fail = 0, total_checks = 0, cyc = 0, bs_m, rf_m, v;
  int lats [6] = '{0, 2, 3, 4, 5, 6};
  int bls [4] = '{1, 2, 3, 7};
  pcra_bus_if bus ();
  pcra_ctrl_end pcra_ctrl_end_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .op_busy(op_busy), .b(bus));
  pcra_mem_end pcra_mem_end_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .b(bus), .arr_wr(arr_wr),
    .arr_addr(arr_addr), .arr_wdata(arr_wdata), .arr_rdata(arr_rdata), .sync_mode(sync_mode),
    .fixed_latency(fixed_latency), .latency_cycles(latency_cycles), .wait_active_high(wait_active_high),
    .wait_early(wait_early), .burst_wrap(burst_wrap), .burst_words(burst_words),
    .burst_continuous(burst_continuous), .setup_unsupported(setup_unsupported), .refresh_setup(refresh_setup));
  pcra_bus_checker pcra_bus_checker_inst (.pclk(pclk), .presetn(presetn), .ce_n(bus.ce_n), .we_n(bus.we_n),
    .oe_n(bus.oe_n), .adv_n(bus.adv_n), .host_dq_oe_n(bus.host_dq_oe_n), .dev_dq_oe_n(bus.dev_dq_oe_n));
  always #4 pclk = ~pclk;
  assign arr_rdata = mem[arr_addr[3:0]];
  assign dec = {sync_mode, fixed_latency, latency_cycles, wait_active_high, wait_early, burst_wrap, burst_words,
    burst_continuous, setup_unsupported};
  always @(posedge pclk) begin
    if (!presetn) begin
      for (int k = 0; k < 16; k++) mem[k] <= 16'(k * 4369);
    end else if (arr_wr) begin
      mem[arr_addr[3:0]] <= arr_wdata;
    end
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Checking and bus tasks
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16
  task automatic chk_dec();
    int lc, bl;
    lc = (bs_m >> 11) & 7;
    bl = bs_m & 7;
    chk16(dec, {~bs_m[15], bs_m[14], (lc == 0) ? 4'h9 : 4'(lc + 1), bs_m[10], bs_m[8], ~bs_m[3],
      (bl == 1) ? 5'h04 : (bl == 2) ? 5'h08 : (bl == 3) ? 5'h10 : 5'h00, bl == 7,
      (bs_m & 32'h02c0) != 0 || ((bs_m >> 4) & 3) == 3 || lc == 1 || lc == 7 || !(bl inside {1, 2, 3, 7})});
  endtask : chk_dec
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic run(input logic [2:0] cmd, input int a, input int d);
    apb(1'b1, pcra_pkg::REG_ADDR, 32'(a));
    apb(1'b1, pcra_pkg::REG_WDATA, 32'(d));
    apb(1'b1, pcra_pkg::REG_CMD, {29'h0, cmd});
    q = 32'h1;
    while (q[0] !== 1'b0) apb(1'b0, pcra_pkg::REG_STATUS, 32'h0);
    chk16({15'h0, op_busy}, 16'h0000);
    apb(1'b0, pcra_pkg::REG_RDATA, 32'h0);
  endtask : run
  function automatic int pcode(input int s);
    return (s == 1) ? 2 : (s == 2) ? 1 : 0;
  endfunction : pcode
  task automatic wr_reg(input int pin, input int sel, input int val);
    if (pin != 0) run(pcra_pkg::CMD_PIN_WR, (pcode(sel) << 18) | val, 0);
    else run(pcra_pkg::CMD_SW_WR, sel, val);
    if (sel == 0) rf_m = val;
    if (sel == 1) bs_m = val;
  endtask : wr_reg
  task automatic rd_chk(input int pin, input int sel);
    if (pin != 0) run(pcra_pkg::CMD_PIN_RD, pcode(sel) << 18, 0);
    else run(pcra_pkg::CMD_SW_RD, sel, 0);
    chk16(q[15:0], (sel == 0) ? 16'(rf_m) : (sel == 1) ? 16'(bs_m) : pcra_pkg::IDENTITY_VAL);
  endtask : rd_chk
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : report_and_stop
  // ==========================================================
  // Main sequence
  initial begin
    bs_m = 32'h1d1f;
    rf_m = pcra_pkg::REFRESH_SETUP_RST;
    void'($urandom(24915));
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk_dec();
    for (int i = 0; i < 6; i++) rd_chk(i / 3, i % 3);
    for (int i = 0; i < 6; i++) begin
      v = ($urandom & 32'hc508) | (lats[i] << 11) | bls[i % 4] | (($urandom % 3) << 4);
      wr_reg(i % 2, 1, v);
      chk_dec();
      rd_chk((i + 1) % 2, 1);
    end
    for (int i = 0; i < 2; i++) begin
      wr_reg(i, 0, $urandom & 32'hffff);
      chk16(refresh_setup, 16'(rf_m));
      wr_reg(i, 2, $urandom & 32'hffff);
      rd_chk(1 - i, 2);
    end
    run(pcra_pkg::CMD_ARR_WR, 5, 32'hbeef);
    run(pcra_pkg::CMD_ARR_RD, 5, 0);
    chk16(q[15:0], 16'hbeef);
    run(pcra_pkg::CMD_ARR_RD, 32'h1fffff, 0);
    chk16(q[15:0], 16'(15 * 4369));
    wr_reg(0, 1, 32'h1d1c);
    chk_dec();
    wr_reg(1, 1, 32'h1d5f);
    chk_dec();
    apb(1'b0, 12'h020, 32'h0);
    chk16({15'h0, err}, 16'h0001);
    // Frozen clock enable must ignore a register write
    clk_en <= 1'b0;
    apb(1'b1, pcra_pkg::REG_ADDR, 32'h0);
    clk_en <= 1'b1;
    apb(1'b0, pcra_pkg::REG_ADDR, 32'h0);
    chk16(q[15:0], 16'h1d5f);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    bs_m = 32'h1d1f;
    rf_m = pcra_pkg::REFRESH_SETUP_RST;
    @(posedge pclk);
    chk_dec();
    rd_chk(0, 1);
    rd_chk(1, 0);
    report_and_stop();
  end
endmodule : psram_config_register_access_tb
